// [rtl/hiod_regs.svh]
/*
  Constants for the host I/O order input decoder: word layout, function codes,
  configuration bit positions and mask, the handover mask, and the configuration reset value.
  Assumes inclusion by bare name from the package and the decoder module.
*/
`ifndef HIOD_REGS_SVH
`define HIOD_REGS_SVH

`define HIOD_WORD_W        16
`define HIOD_BOARD_W       6
`define HIOD_LINE_W        4
`define HIOD_FC_W          6
`define HIOD_FC_LSB        0
`define HIOD_LINE_LSB      6
`define HIOD_BOARD_LSB     10

`define HIOD_FC_CTRL_BYTE  6'h0e
`define HIOD_FC_RANGE      6'h0c
`define HIOD_FC_STATUS     6'h18
`define HIOD_FC_NEXT_STAT  6'h1a
`define HIOD_FC_CONFIG_IN  6'h10
`define HIOD_FC_CONFIG_OUT 6'h11
`define HIOD_FC_LINE_STAT  6'h1c
`define HIOD_FC_DEV_ID     6'h26
`define HIOD_FC_EXT_ID     6'h08
`define HIOD_FC_FW_REV     6'h04

// Word bit 0 is the leftmost bit, so documented bits 0, 3 and 4 sit at 15, 12 and 11.
`define HIOD_CFG_EXT_MODE  15
`define HIOD_CFG_RESTART   12
`define HIOD_CFG_LCT_WRITE 11
`define HIOD_CFG_MASK      16'h9800
`define HIOD_CFG_RESET     16'h0000

`define HIOD_CB_HANDOVER_MASK 8'h1f

`endif

// [rtl/hiod_pkg.sv]
/*
  Types shared by the host I/O order input decoder.
  Assumes the constants header is on the include path.
*/
`include "hiod_regs.svh"

package hiod_pkg;
  typedef logic [`HIOD_WORD_W-1:0]  hiod_word_t;
  typedef logic [`HIOD_FC_W-1:0]    hiod_fc_t;
  typedef logic [`HIOD_LINE_W-1:0]  hiod_line_t;
  typedef logic [`HIOD_BOARD_W-1:0] hiod_board_t;
  typedef enum logic [1:0] {HIOD_IDLE, HIOD_ANSWER} hiod_state_t;
endpackage

// [rtl/hiod_decoder.sv]
/*
  Host I/O order decoder for one board: takes a channel/function word with an
  operand, answers input orders with a 16-bit word, stores configuration words,
  advances the per-channel status pointer and flags illegal function codes.
  Assumes the control-block store, line units and adapters outside present
  the selected channel's bytes combinationally and that the status pointer
  storage lives here as a per-channel index presented back to that store.
*/
// Function
// R01: Top six bits board, next four line
// R02: Low six bits code; odd writes
// R03: Orders acknowledged at once, refusals flagged
// R04: Code 0e returns current control byte
// R05: Handover reloads control bits 3-7 first
// R06: Code 0c returns range bytes 4,3
// R07: Code 18 returns status bytes 7,6
// R08: Status word bit positions as documented
// R09: Host ignores status until complete
// R10: Status read keeps the status pointer
// R11: Polling host repeats non-advancing read
// R12: Code 1a advances status pointer
// R13: Code 10 returns configuration, bit0 extended
// R14: Configuration bit3 permits master clear
// R15: Configuration bit4 line-table write permit
// R16: Code 1c passes line-unit status through
// R17: Code 26 returns fixed device identification
// R18: Code 08 returns adapter, unit ident
// R19: Code 04 returns both firmware revisions
// R20: Host loads channel program before start
// R21: Host starts program by channel control
// R22: Unknown code sets illegal flag, stops
// R23: One word answered, reserved bits zero
`timescale 1ns/1ps
`include "hiod_regs.svh"

module hiod_decoder #(
  parameter int                   LINES      = 16,
  parameter logic [5:0]           BOARD_ID   = 6'h01,
  parameter logic [15:0]          DEVICE_ID  = 16'h5a5a, // Arbitrary value.
  parameter logic [7:0]           BUS_FW_REV = 8'h01,
  parameter logic [7:0]           CCP_FW_REV = 8'h01
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               order_valid,
  input  wire hiod_pkg::hiod_word_t channel_function_word,
  input  wire hiod_pkg::hiod_word_t host_operand,
  input  wire logic [7:0]         comm_control_block_ctrl,
  input  wire logic [7:0]         line_control_table_ctrl,
  input  wire logic               block_handover_op_done,
  input  wire logic [7:0]         comm_control_block_byte3,
  input  wire logic [7:0]         comm_control_block_byte4,
  input  wire logic [7:0]         comm_control_block_byte6,
  input  wire logic [7:0]         comm_control_block_byte7,
  input  wire hiod_pkg::hiod_word_t line_unit_status_reg,
  input  wire logic [3:0]         adapter_ident_reg,
  input  wire logic [3:0]         line_unit_ident_reg,
  output logic                    order_ack,
  output logic                    order_refused,
  output hiod_pkg::hiod_word_t    answer_data,
  output logic                    answer_valid,
  output hiod_pkg::hiod_line_t    line_select,
  output logic [LINES*4-1:0]      status_pointer,
  output logic [LINES-1:0]        illegal_function_flag,
  output logic [LINES-1:0]        stop_io,
  output logic [LINES-1:0]        extended_mode,
  output logic [LINES-1:0]        master_clear_permit,
  output logic [LINES-1:0]        line_table_write_permit
);
  import hiod_pkg::*;

  hiod_word_t  config_r [LINES];
  hiod_word_t  answer_nxt;
  hiod_board_t board_sel;
  hiod_line_t  line_sel;
  hiod_fc_t    function_code;
  logic        for_us;
  logic        is_write;
  logic        known_code;
  logic        line_ok;
  logic [7:0]  ctrl_byte;
  hiod_word_t  status_word;

  assign board_sel     = channel_function_word[`HIOD_BOARD_LSB +: `HIOD_BOARD_W]; // R01
  assign line_sel      = channel_function_word[`HIOD_LINE_LSB +: `HIOD_LINE_W]; // R01
  assign function_code = channel_function_word[`HIOD_FC_LSB +: `HIOD_FC_W]; // R02
  assign is_write      = function_code[0]; // R02
  assign for_us        = order_valid && (board_sel == BOARD_ID);
  // A line channel with no adapter behind it cannot serve the order.
  assign line_ok       = 32'(line_sel) < LINES; // R01

  // Handover reloads bits 3-7 from the line table before the byte goes out.
  assign ctrl_byte = block_handover_op_done
    ? ((comm_control_block_ctrl & ~`HIOD_CB_HANDOVER_MASK)
       | (line_control_table_ctrl & `HIOD_CB_HANDOVER_MASK))
    : comm_control_block_ctrl; // R05

  // Byte 7 carries bits 0-7 (left), byte 6 bits 8-15 (right), bit 0 as MSB.
  assign status_word = {comm_control_block_byte7, comm_control_block_byte6}; // R07 R08

  assign known_code = (function_code == `HIOD_FC_CTRL_BYTE)
                   || (function_code == `HIOD_FC_RANGE)
                   || (function_code == `HIOD_FC_STATUS)
                   || (function_code == `HIOD_FC_NEXT_STAT)
                   || (function_code == `HIOD_FC_CONFIG_IN)
                   || (function_code == `HIOD_FC_CONFIG_OUT)
                   || (function_code == `HIOD_FC_LINE_STAT)
                   || (function_code == `HIOD_FC_DEV_ID)
                   || (function_code == `HIOD_FC_EXT_ID)
                   || (function_code == `HIOD_FC_FW_REV);

  always_comb
  begin
    answer_nxt = 16'h0000; // R23
    unique case (function_code)
      `HIOD_FC_CTRL_BYTE: answer_nxt = {ctrl_byte, 8'h00}; // R04 R23
      `HIOD_FC_RANGE:     answer_nxt = {comm_control_block_byte4,
                                        comm_control_block_byte3}; // R06
      `HIOD_FC_STATUS:    answer_nxt = status_word; // R07 R10
      `HIOD_FC_NEXT_STAT: answer_nxt = status_word; // R12
      `HIOD_FC_CONFIG_IN: answer_nxt = config_r[line_sel[$clog2(LINES)-1:0]]
                                       & `HIOD_CFG_MASK; // R13 R15
      `HIOD_FC_LINE_STAT: answer_nxt = line_unit_status_reg; // R16
      `HIOD_FC_DEV_ID:    answer_nxt = DEVICE_ID; // R17
      `HIOD_FC_EXT_ID:    answer_nxt = {adapter_ident_reg, line_unit_ident_reg,
                                        8'h00}; // R18
      `HIOD_FC_FW_REV:    answer_nxt = {BUS_FW_REV, CCP_FW_REV}; // R19
      default:            answer_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      order_ack     <= 1'b0;
      order_refused <= 1'b0;
      answer_valid  <= 1'b0;
      answer_data   <= 16'h0000;
      line_select   <= 4'h0;
    end
    else
    begin
      order_ack     <= for_us && line_ok && known_code; // R03
      order_refused <= for_us && !(line_ok && known_code); // R03
      answer_valid  <= for_us && line_ok && known_code && !is_write; // R02
      // A refused read must not leak a half-decoded word onto the answer lines.
      answer_data   <= (for_us && line_ok && known_code && !is_write)
                       ? answer_nxt : 16'h0000; // R23
      line_select   <= line_sel;
    end
  end

  // Per-channel state: configuration, status pointer, illegal flag and stop.
  for (genvar ch = 0; ch < LINES; ch++)
  begin : g_chan
    logic hit;
    assign hit = for_us && (32'(line_sel) == ch);

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        config_r[ch]                <= `HIOD_CFG_RESET;
        status_pointer[ch*4 +: 4]   <= 4'h0;
        illegal_function_flag[ch]   <= 1'b0;
        stop_io[ch]                 <= 1'b0;
      end
      else
      begin
        if (hit && function_code == `HIOD_FC_CONFIG_OUT)
          config_r[ch] <= host_operand & `HIOD_CFG_MASK; // R15
        if (hit && function_code == `HIOD_FC_NEXT_STAT)
          status_pointer[ch*4 +: 4] <= status_pointer[ch*4 +: 4] + 4'h1; // R12
        // The flag is sticky here; clearing belongs to the interrupt status read.
        if (hit && !known_code)
          illegal_function_flag[ch] <= 1'b1; // R22
        stop_io[ch] <= hit && !known_code; // R22
      end
    end

    assign extended_mode[ch]           = config_r[ch][`HIOD_CFG_EXT_MODE]; // R13
    assign master_clear_permit[ch]     = config_r[ch][`HIOD_CFG_RESTART]; // R14
    assign line_table_write_permit[ch] = config_r[ch][`HIOD_CFG_LCT_WRITE]; // R15
  end

endmodule

// [sim/hiod_decoder_chk.sv]
/* Port assertions for the order decoder.
   Assumes it is bound into hiod_decoder with the same parameters. */
`timescale 1ns/1ps
module hiod_decoder_chk #(
  parameter int          LINES      = 16,
  parameter logic [5:0]  BOARD_ID   = 6'h01,
  parameter logic [15:0] DEVICE_ID  = 16'h5a5a,
  parameter logic [7:0]  BUS_FW_REV = 8'h01,
  parameter logic [7:0]  CCP_FW_REV = 8'h01
) (
  input wire logic                 clock,
  input wire logic                 reset,
  input wire logic                 order_valid,
  input wire hiod_pkg::hiod_word_t channel_function_word,
  input wire logic                 order_ack,
  input wire logic                 order_refused,
  input wire hiod_pkg::hiod_word_t answer_data,
  input wire logic                 answer_valid,
  input wire logic [LINES*4-1:0]   status_pointer
);
  import hiod_pkg::*;
  wire logic [5:0] fc = channel_function_word[5:0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence taken_s;
    order_valid && channel_function_word[15:10] == BOARD_ID;
  endsequence
  one_answer_a: assert property (taken_s |=> order_ack ^ order_refused)
    else $error("order not answered exactly once");
  foreign_board_a: assert property (order_valid && channel_function_word[15:10] != BOARD_ID
    |=> !order_ack && !order_refused) else $error("foreign order answered");
  write_silent_a: assert property ((taken_s ##0 fc[0]) |=> !answer_valid)
    else $error("write order returned data");
  read_answer_a: assert property ((taken_s ##0 !fc[0]) |=> answer_valid ^ order_refused)
    else $error("read order neither answered nor refused");
  status_keep_a: assert property ((taken_s ##0 fc == 6'h18) |=> $stable(status_pointer))
    else $error("status read moved the pointer");
  ptr_advance_a: assert property ((taken_s ##0 fc == 6'h1a)
    |=> status_pointer != $past(status_pointer)) else $error("pointer kept");
  device_id_a: assert property ((taken_s ##0 fc == 6'h26) |=> answer_data == DEVICE_ID)
    else $error("wrong device identification");
  fw_rev_a: assert property ((taken_s ##0 fc == 6'h04)
    |=> answer_data == {BUS_FW_REV, CCP_FW_REV}) else $error("wrong revisions");
  idle_zero_a: assert property (!answer_valid |-> answer_data == 16'h0000)
    else $error("answer word not zero while idle");
endmodule
bind hiod_decoder hiod_decoder_chk #(.LINES(LINES), .BOARD_ID(BOARD_ID), .DEVICE_ID(DEVICE_ID),
  .BUS_FW_REV(BUS_FW_REV), .CCP_FW_REV(CCP_FW_REV)) hiod_decoder_chk_i (.clock(clock),
  .reset(reset), .order_valid(order_valid), .channel_function_word(channel_function_word),
  .order_ack(order_ack), .order_refused(order_refused), .answer_data(answer_data),
  .answer_valid(answer_valid), .status_pointer(status_pointer));

// [sim/hiod_store_model.sv]
/* Control block store: presents the top block bytes of the selected line.
   Assumes the bench drives line_select from the order word and the decoder drives status_pointer. */
`timescale 1ns/1ps
module hiod_store_model #(
  parameter int LINES = 16
) (
  input  wire hiod_pkg::hiod_line_t line_select,
  input  wire logic [LINES*4-1:0]   status_pointer,
  output logic [7:0]                byte3,
  output logic [7:0]                byte4,
  output logic [7:0]                byte6,
  output logic [7:0]                byte7
);
  import hiod_pkg::*;
  wire logic [3:0] ptr = status_pointer[int'(line_select)*4 +: 4];
  assign byte3 = {ptr, line_select};
  assign byte4 = {line_select, ptr};
  assign byte6 = ~{ptr, line_select};
  // Blocks are always complete, so the host may trust every status read.
  assign byte7 = {3'h0, 1'b1, ptr};
endmodule

// [sim/hiod_decoder_tb.sv]
/* Self-checking bench for the order decoder with a store model.
   Assumes the package and checker are compiled first. */
`timescale 1ns/1ps
module hiod_decoder_tb;
  import hiod_pkg::*;
  localparam logic [15:0] DID = 16'h1234; // Arbitrary value.
  logic        clock = 1'b0, reset = 1'b1, order_valid = 1'b0, hand = 1'b0;
  hiod_word_t  cfw = 16'h0000, op = 16'h0000, lus = 16'hc3a5, ans;
  logic [7:0]  cb = 8'ha6, line_control_table = 8'h4b, b3, b4, b6, b7;
  logic        ack, rf, av;
  hiod_line_t  ls;
  logic [63:0] sp;
  logic [15:0] ilf, em, mcp, ltw, sio;
  logic [3:0]  p = 4'h0;
  int          failures = 0, checked = 0, cyc = 0;
  hiod_decoder #(.BOARD_ID(6'h21), .DEVICE_ID(DID), .BUS_FW_REV(8'h12), .CCP_FW_REV(8'h34))
  hiod_decoder_i (.clock, .reset, .order_valid, .channel_function_word(cfw), .host_operand(op),
    .comm_control_block_ctrl(cb), .line_control_table_ctrl(line_control_table), .block_handover_op_done(hand),
    .comm_control_block_byte3(b3), .comm_control_block_byte4(b4),
    .comm_control_block_byte6(b6), .comm_control_block_byte7(b7), .line_unit_status_reg(lus),
    .adapter_ident_reg(4'h9), .line_unit_ident_reg(4'h6), .order_ack(ack), .order_refused(rf),
    .answer_data(ans), .answer_valid(av), .line_select(ls), .status_pointer(sp),
    .illegal_function_flag(ilf), .stop_io(sio), .extended_mode(em), .master_clear_permit(mcp),
    .line_table_write_permit(ltw));
  // The store answers for the line on the bus now; line_select lags by one cycle.
  hiod_store_model hiod_store_model_i (.line_select(cfw[9:6]), .status_pointer(sp), .byte3(b3),
    .byte4(b4), .byte6(b6), .byte7(b7));
  task automatic chk(input hiod_word_t seen, input hiod_word_t exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // The answer is registered, so it is sampled just after the taking edge.
  task automatic io(input hiod_fc_t fc, input hiod_line_t ln, input hiod_word_t d,
                    input logic [5:0] brd = 6'h21);
    @(posedge clock);
    #1 {order_valid, cfw, op} = {1'b1, brd, ln, fc, d};
    @(posedge clock);
    #1 order_valid = 1'b0;
  endtask
  task automatic t_config;
    chk(em, 16'h0000);
    io(6'h11, 4'h2, 16'hffff);
    chk(16'(ack), 16'h0001);
    io(6'h10, 4'h2, 16'h0000);
    chk(ans, 16'h9800);
    chk(16'({em[2], mcp[2], ltw[2]}), 16'h0007);
    io(6'h10, 4'h3, 16'h0000);
    chk(ans, 16'h0000);
  endtask
  task automatic t_ctrl;
    io(6'h0e, 4'h3, 16'h0000);
    chk(ans, {cb, 8'h00});
    hand = 1'b1;
    io(6'h0e, 4'h3, 16'h0000);
    chk(ans, {cb[7:5], line_control_table[4:0], 8'h00});
    hand = 1'b0;
  endtask
  task automatic t_block;
    io(6'h0c, 4'h3, 16'h0000);
    chk(ans, {4'h3, p, p, 4'h3});
    chk(16'(ls), 16'h0003);
    repeat (2) io(6'h18, 4'h3, 16'h0000);
    chk(ans, {4'h1, p, ~p, 4'hc});
    io(6'h1a, 4'h3, 16'h0000);
    p++;
    chk(16'(sp[15:12]), 16'(p));
    io(6'h18, 4'h3, 16'h0000);
    chk(ans, {4'h1, p, ~p, 4'hc});
  endtask
  task automatic t_ids;
    io(6'h26, 4'h1, 16'h0000);
    chk(ans, DID);
    io(6'h08, 4'h1, 16'h0000);
    chk(ans, 16'h9600);
    io(6'h04, 4'h1, 16'h0000);
    chk(ans, 16'h1234);
    io(6'h1c, 4'h1, 16'h0000);
    chk(ans, lus);
  endtask
  task automatic t_refuse;
    io(6'h2e, 4'h5, 16'h0000);
    chk(16'({rf, av, ack, ilf[5]}), 16'h0009);
    chk(sio, 16'h0020);
    io(6'h0e, 4'h3, 16'h0000, 6'h22);
    chk(16'({ack, rf, av}), 16'h0000);
  endtask
  task automatic stop_test;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #25 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    #1 reset = 1'b0;
    // no channel program is loaded or started; only input, configuration and one illegal-code order run.
    t_config();
    t_ctrl();
    t_block();
    t_ids();
    t_refuse();
    stop_test();
  end
endmodule
